// >>> sic_pkg.sv
package sic_pkg;

	// register byte addresses
	localparam logic [15:0] SIC_ADDR_STATUS = 16'h8504;
	localparam logic [15:0] SIC_ADDR_ADVFN  = 16'h850c;

	// flag positions, shared by status and write-one clear bits
	localparam int SIC_NUM_FLAGS     = 7;
	localparam int SIC_FLAG_VSYNC    = 0;
	localparam int SIC_FLAG_ENGDONE  = 1;
	localparam int SIC_FLAG_OVF      = 2;
	localparam int SIC_FLAG_EMPTY    = 3;
	localparam int SIC_FLAG_HOSTDMA  = 4;
	localparam int SIC_FLAG_CMDDMA   = 5;
	localparam int SIC_FLAG_ENGFIFO  = 6;

	// status word fields
	localparam int SIC_STAT_PBIRQ    = 7;
	localparam int SIC_STAT_FREE_LO  = 8;
	localparam int SIC_STAT_FREE_HI  = 12;
	localparam int SIC_STAT_IDLE     = 13;

	// control word enable positions
	localparam int SIC_EN_HOSTDMA    = 7;
	localparam int SIC_EN_VSYNC      = 8;
	localparam int SIC_EN_ENGDONE    = 9;
	localparam int SIC_EN_OVF        = 10;
	localparam int SIC_EN_EMPTY      = 11;
	localparam int SIC_EN_CMDDMA     = 12;
	localparam int SIC_EN_ENGFIFO    = 13;
	localparam int SIC_RST_LO        = 14;
	localparam int SIC_RST_HI        = 15;

	// engine software reset codes
	localparam logic [1:0] SIC_RST_KEEP   = 2'h0;
	localparam logic [1:0] SIC_RST_ENABLE = 2'h1;
	localparam logic [1:0] SIC_RST_RESET  = 2'h2;

	// advanced function fields
	localparam int SIC_ADV_ENH       = 0;
	localparam int SIC_ADV_DMARST    = 1;
	localparam int SIC_ADV_LINEAR    = 4;
	localparam int SIC_ADV_FREE_LO   = 6;
	localparam int SIC_ADV_FREE_HI   = 9;

	// reset values
	localparam logic [6:0]  SIC_FLAGS_RST = 7'h00;
	localparam logic [6:0]  SIC_EN_RST    = 7'h00;
	localparam logic [31:0] SIC_DATA_RST  = 32'h00000000;

	typedef enum logic [0:0] {
		SIC_ENG_RUN   = 1'b0,
		SIC_ENG_RESET = 1'b1
	} sic_eng_type;

	// event and state inputs from the surrounding engine logic
	typedef struct packed {
		logic       engineIdle;
		logic       cmdFifoOverflow;
		logic       cmdFifoEmpty;
		logic       hostDmaDone;
		logic       cmdDmaDone;
		logic       engineFifoEmpty;
		logic       peripheralBusIrq;
		logic [4:0] engineFifoFree;
		logic [3:0] cmdFifoFree;
	} sic_event_type;

	// configuration bits held elsewhere in the device
	typedef struct packed {
		logic globalIrqEnable;
		logic engineResetConfigBit;
		logic enhancedModeConfig;
		logic linearAddrConfig;
	} sic_config_type;

endpackage

// >>> sic_irq_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - status bits 0..6 report seven sticky interrupt flags, 1 when raised
// - status bit 7 reports the peripheral bus interrupt
// - status bits 12..8 report engine fifo free slots, 0 to 16
// - reads at 8504 give status; writes go to unreadable control word
// - control bits 0..6 written 1 clear matching flag; 0 leaves it
// - control bits 7..13 hold one interrupt enable per source
// - a source interrupts only when its enable and global enable are 1
// - events: vsync active, engine idle, fifo overflow/empty, dma completion
// - control bits 15..14: 00 keep, 01 enable, 10 reset, 11 reserved
// - engine reset config bit acts like writing reset code 10
// - advanced bit 0 selects enhanced modes, ored with its config bit
// - advanced bit 1 written 1 resets read dma pointers
// - advanced bit 4 enables linear addressing, ored with config bit
// - advanced bits 9..6 report command fifo free slots, 0 to 8
module sic_irq_ctrl
	import sic_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           rstn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [15:0]    paddr,
	input  wire logic [31:0]    pwdata,
	output logic      [31:0]    prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           vsyncPin,
	input  wire sic_event_type  events,
	input  wire sic_config_type config_i,
	output logic                irq,
	output logic                engineSoftReset,
	output logic                enhancedModeSelect,
	output logic                linearAddressingEnable,
	output logic                readDmaPointerReset
);

	// map control word enables onto the flag order
	function automatic logic [6:0] enableOrder(input logic [31:0] w);
		logic [6:0] e;
		e = '0;
		e[SIC_FLAG_VSYNC]   = w[SIC_EN_VSYNC];
		e[SIC_FLAG_ENGDONE] = w[SIC_EN_ENGDONE];
		e[SIC_FLAG_OVF]     = w[SIC_EN_OVF];
		e[SIC_FLAG_EMPTY]   = w[SIC_EN_EMPTY];
		e[SIC_FLAG_HOSTDMA] = w[SIC_EN_HOSTDMA];
		e[SIC_FLAG_CMDDMA]  = w[SIC_EN_CMDDMA];
		e[SIC_FLAG_ENGFIFO] = w[SIC_EN_ENGFIFO];
		return e;
	endfunction

	logic        vsyncMeta_q;
	logic        vsyncSync_q;
	logic [6:0]  level_d;
	logic [6:0]  level_q;
	logic [6:0]  rise;
	logic [6:0]  flags_q;
	logic [6:0]  flags_d;
	logic [6:0]  enables_q;
	logic [6:0]  clearMask;
	logic        setupPhase;
	logic        accessDone;
	logic        wrStatus;
	logic        wrAdv;
	logic        addrHit;
	sic_eng_type engState_q;
	logic        advEnh_q;
	logic        advDmaRst_q;
	logic        advLinear_q;
	logic [31:0] statusWord;
	logic [31:0] advWord;

	// vsync arrives from a pin; first stage feeds only the second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			vsyncMeta_q <= 1'b0;
			vsyncSync_q <= 1'b0;
		end else begin
			vsyncMeta_q <= vsyncPin;
			vsyncSync_q <= vsyncMeta_q;
		end
	end

	always_comb begin
		level_d = '0;
		level_d[SIC_FLAG_VSYNC]   = vsyncSync_q;
		level_d[SIC_FLAG_ENGDONE] = events.engineIdle;
		level_d[SIC_FLAG_OVF]     = events.cmdFifoOverflow;
		level_d[SIC_FLAG_EMPTY]   = events.cmdFifoEmpty;
		level_d[SIC_FLAG_HOSTDMA] = events.hostDmaDone;
		level_d[SIC_FLAG_CMDDMA]  = events.cmdDmaDone;
		level_d[SIC_FLAG_ENGFIFO] = events.engineFifoEmpty;
	end

	// levels start low so a source already high at reset raises its flag once
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			level_q <= SIC_FLAGS_RST;
		end else begin
			level_q <= level_d;
		end
	end

	assign rise = level_d & ~level_q;

	// bus decode
	assign setupPhase = psel && !penable;
	assign accessDone = psel && penable && pready;
	assign addrHit    = (paddr == SIC_ADDR_STATUS) || (paddr == SIC_ADDR_ADVFN);
	// a write at the status offset lands in the control word
	assign wrStatus   = accessDone && pwrite && (paddr == SIC_ADDR_STATUS);
	assign wrAdv      = accessDone && pwrite && (paddr == SIC_ADDR_ADVFN);

	assign clearMask = wrStatus ? pwdata[SIC_NUM_FLAGS-1:0] : 7'h00;

	// sticky; a new event beats a clear in the same cycle
	assign flags_d = (flags_q & ~clearMask) | rise;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= SIC_FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// enables live in the write-only control word
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			enables_q <= SIC_EN_RST;
		end else if (wrStatus) begin
			enables_q <= enableOrder(pwdata);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= (|(flags_d & enables_q)) && config_i.globalIrqEnable;
		end
	end

	// engine software reset field; reserved code keeps state
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			engState_q <= SIC_ENG_RUN;
		end else if (wrStatus) begin
			case (pwdata[SIC_RST_HI:SIC_RST_LO])
				SIC_RST_ENABLE: begin
					engState_q <= SIC_ENG_RUN;
				end
				SIC_RST_RESET: begin
					engState_q <= SIC_ENG_RESET;
				end
				default: begin
					engState_q <= engState_q;
				end
			endcase
		end
	end

	// config bit forces reset like code 10
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			engineSoftReset <= 1'b0;
		end else begin
			engineSoftReset <= (engState_q == SIC_ENG_RESET) || config_i.engineResetConfigBit;
		end
	end

	// advanced function read/write bits
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			advEnh_q    <= 1'b0;
			advDmaRst_q <= 1'b0;
			advLinear_q <= 1'b0;
		end else if (wrAdv) begin
			advEnh_q    <= pwdata[SIC_ADV_ENH];
			advDmaRst_q <= pwdata[SIC_ADV_DMARST];
			advLinear_q <= pwdata[SIC_ADV_LINEAR];
		end
	end

	// effective mode outputs; level so software's 1-then-0 pulse is seen
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			enhancedModeSelect     <= 1'b0;
			linearAddressingEnable <= 1'b0;
			readDmaPointerReset    <= 1'b0;
		end else begin
			enhancedModeSelect     <= advEnh_q || config_i.enhancedModeConfig;
			linearAddressingEnable <= advLinear_q || config_i.linearAddrConfig;
			// pointer reset while bit holds 1
			readDmaPointerReset    <= advDmaRst_q;
		end
	end

	// read words; reserved bits read zero
	always_comb begin
		statusWord = SIC_DATA_RST;
		statusWord[SIC_NUM_FLAGS-1:0] = flags_q;
		statusWord[SIC_STAT_PBIRQ] = events.peripheralBusIrq;
		statusWord[SIC_STAT_FREE_HI:SIC_STAT_FREE_LO] = events.engineFifoFree;
		statusWord[SIC_STAT_IDLE] = events.engineIdle;
		advWord = SIC_DATA_RST;
		advWord[SIC_ADV_ENH]    = advEnh_q;
		advWord[SIC_ADV_DMARST] = advDmaRst_q;
		advWord[SIC_ADV_LINEAR] = advLinear_q;
		advWord[SIC_ADV_FREE_HI:SIC_ADV_FREE_LO] = events.cmdFifoFree;
	end

	// one wait-free access phase: answer loaded during setup
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= SIC_DATA_RST;
		end else begin
			pready  <= setupPhase;
			pslverr <= setupPhase && !addrHit;
			if (setupPhase && !pwrite && paddr == SIC_ADDR_STATUS) begin
				prdata <= statusWord;
			end else if (setupPhase && !pwrite && paddr == SIC_ADDR_ADVFN) begin
				prdata <= advWord;
			end else if (setupPhase) begin
				prdata <= SIC_DATA_RST;
			end
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence clearWrite(int b);
		wrStatus && pwdata[b];
	endsequence

	flag_sticky_a: assert property (
		flags_q[SIC_FLAG_VSYNC] && !clearMask[SIC_FLAG_VSYNC] |=> flags_q[SIC_FLAG_VSYNC])
		else $error("vsync flag dropped without a clear");

	flag_clear_a: assert property (
		clearWrite(SIC_FLAG_OVF) ##0 !rise[SIC_FLAG_OVF] |=> !flags_q[SIC_FLAG_OVF])
		else $error("overflow flag not cleared by write one");

	set_wins_a: assert property (
		rise[SIC_FLAG_HOSTDMA] |=> flags_q[SIC_FLAG_HOSTDMA])
		else $error("host dma event lost");

	vsync_edge_a: assert property (
		$rose(vsyncSync_q) |=> flags_q[SIC_FLAG_VSYNC])
		else $error("vsync edge did not raise flag");

	irq_gate_a: assert property (
		!config_i.globalIrqEnable |=> !irq)
		else $error("irq raised with global enable off");

	irq_cause_a: assert property (
		config_i.globalIrqEnable && (|(flags_d & enables_q)) |=> irq)
		else $error("enabled flag failed to raise irq");

	eng_reset_a: assert property (
		wrStatus && pwdata[SIC_RST_HI:SIC_RST_LO] == SIC_RST_RESET |=> ##1 engineSoftReset)
		else $error("reset code did not reset engine");

	eng_cfg_a: assert property (
		config_i.engineResetConfigBit |=> engineSoftReset)
		else $error("config reset bit ignored");

	status_read_a: assert property (
		setupPhase && !pwrite && paddr == SIC_ADDR_STATUS
		|=> pready && prdata[SIC_NUM_FLAGS-1:0] == $past(flags_q))
		else $error("status read returned wrong flags");

	lin_or_a: assert property (
		config_i.linearAddrConfig |=> linearAddressingEnable)
		else $error("linear addressing config not ored");

	dma_rst_a: assert property (
		wrAdv && pwdata[SIC_ADV_DMARST] |=> ##1 readDmaPointerReset)
		else $error("pointer reset not driven");

	sequence statusRead;
		setupPhase && !pwrite && paddr == SIC_ADDR_STATUS;
	endsequence

	sequence advRead;
		setupPhase && !pwrite && paddr == SIC_ADDR_ADVFN;
	endsequence

	// pin edge takes two synchroniser stages before the edge detector sees it
	sequence pinRise;
		!vsyncPin ##1 vsyncPin;
	endsequence

	sequence idleRise;
		!events.engineIdle ##1 events.engineIdle;
	endsequence

	ready_one_a: assert property (
		setupPhase |=> pready)
		else $error("access phase not answered at once");

	ready_drop_a: assert property (
		pready |=> !pready)
		else $error("ready held beyond one cycle");

	unmapped_err_a: assert property (
		setupPhase && !addrHit |=> pslverr && prdata == SIC_DATA_RST)
		else $error("unmapped access not refused");

	free_slots_a: assert property (
		statusRead
		|=> prdata[SIC_STAT_FREE_HI:SIC_STAT_FREE_LO] == $past(events.engineFifoFree))
		else $error("engine fifo free slots misreported");

	idle_bit_a: assert property (
		statusRead |=> prdata[SIC_STAT_IDLE] == $past(events.engineIdle))
		else $error("engine idle bit misreported");

	pbirq_bit_a: assert property (
		statusRead |=> prdata[SIC_STAT_PBIRQ] == $past(events.peripheralBusIrq))
		else $error("peripheral bus interrupt bit misreported");

	cmd_slots_a: assert property (
		advRead
		|=> prdata[SIC_ADV_FREE_HI:SIC_ADV_FREE_LO] == $past(events.cmdFifoFree))
		else $error("command fifo free slots misreported");

	clear_keep_a: assert property (
		flags_q[SIC_FLAG_ENGDONE] && wrStatus && !pwdata[SIC_FLAG_ENGDONE]
		|=> flags_q[SIC_FLAG_ENGDONE])
		else $error("zero in clear bit dropped a flag");

	en_write_a: assert property (
		wrStatus && pwdata[SIC_EN_HOSTDMA] |=> enables_q[SIC_FLAG_HOSTDMA])
		else $error("host dma enable not stored");

	eng_run_a: assert property (
		wrStatus && pwdata[SIC_RST_HI:SIC_RST_LO] == SIC_RST_ENABLE
		##1 !config_i.engineResetConfigBit |=> !engineSoftReset)
		else $error("enable code did not release engine");

	eng_keep_a: assert property (
		wrStatus && pwdata[SIC_RST_HI] == pwdata[SIC_RST_LO] |=> $stable(engState_q))
		else $error("keep or reserved code changed engine state");

	enh_or_a: assert property (
		config_i.enhancedModeConfig |=> enhancedModeSelect)
		else $error("enhanced mode config not ored");

	irq_idle_a: assert property (
		(flags_d & enables_q) == 7'h00 |=> !irq)
		else $error("irq raised with no enabled flag");

	vsync_pin_a: assert property (
		pinRise |=> ##2 flags_q[SIC_FLAG_VSYNC])
		else $error("vsync pin edge did not raise flag");

	done_event_a: assert property (
		idleRise |=> flags_q[SIC_FLAG_ENGDONE])
		else $error("engine idle edge did not raise done flag");

endmodule

// >>> tb_sic_irq_ctrl.sv
`timescale 1ns/1ps
module tb_sic_irq_ctrl
	import sic_pkg::*;
;
	logic           mclk;
	logic           rstn;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [15:0]    paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic           vsyncPin;
	sic_event_type  events;
	sic_config_type cfg;
	logic           irq;
	logic           engineSoftReset;
	logic           enhancedModeSelect;
	logic           linearAddressingEnable;
	logic           readDmaPointerReset;
	logic [31:0]    rd;
	logic           er;
	int             fails;
	int             n_checks;

	localparam int EN_POS [7] = '{SIC_EN_VSYNC, SIC_EN_ENGDONE, SIC_EN_OVF, SIC_EN_EMPTY,
		SIC_EN_HOSTDMA, SIC_EN_CMDDMA, SIC_EN_ENGFIFO};
	localparam logic [1:0] RST_SEQ [4] = '{SIC_RST_RESET, SIC_RST_KEEP, SIC_RST_ENABLE, 2'h3};
	localparam logic       RST_EXP [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

	sic_irq_ctrl uut (
		.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vsyncPin(vsyncPin), .events(events), .config_i(cfg),
		.irq(irq), .engineSoftReset(engineSoftReset),
		.enhancedModeSelect(enhancedModeSelect),
		.linearAddressingEnable(linearAddressingEnable),
		.readDmaPointerReset(readDmaPointerReset)
	);

	always #25 mclk = ~mclk;

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// wait states are tolerated: the access phase lasts until pready is sampled, up to 16 cycles
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			$display("[FAIL] pready expected 1 seen %b", pready);
			fails++;
			close_out;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task setEv(input int i, input logic v);
		case (i)
			0: vsyncPin <= v;
			1: events.engineIdle <= v;
			2: events.cmdFifoOverflow <= v;
			3: events.cmdFifoEmpty <= v;
			4: events.hostDmaDone <= v;
			5: events.cmdDmaDone <= v;
			default: events.engineFifoEmpty <= v;
		endcase
	endtask

	task t_flags;
		logic [6:0] m;
		m = 7'h00;
		apb(1'b0, SIC_ADDR_STATUS, 32'h0);
		chk("status after reset", 32'h0, rd);
		for (int i = 0; i < SIC_NUM_FLAGS; i++) begin
			setEv(i, 1'b1);
			tick(4);
			m[i] = 1'b1;
			apb(1'b0, SIC_ADDR_STATUS, 32'h0);
			chk("flags set", {25'h0, m}, {25'h0, rd[6:0]});
		end
		for (int i = 0; i < SIC_NUM_FLAGS; i++)
			setEv(i, 1'b0);
		tick(2);
		apb(1'b1, SIC_ADDR_STATUS, 32'h00000005);
		tick(3);
		apb(1'b0, SIC_ADDR_STATUS, 32'h0);
		chk("flags clear", 32'h7a, {25'h0, rd[6:0]});
		$display("t_flags done");
	endtask

	// flags 1,3,4,5,6 are left set by t_flags
	task t_irq;
		cfg.globalIrqEnable <= 1'b1;
		for (int i = 0; i < SIC_NUM_FLAGS; i++) begin
			apb(1'b1, SIC_ADDR_STATUS, 32'h1 << EN_POS[i]);
			tick(3);
			chk("irq per source", (i == 0 || i == 2) ? 32'h0 : 32'h1, {31'h0, irq});
		end
		cfg.globalIrqEnable <= 1'b0;
		apb(1'b1, SIC_ADDR_STATUS, 32'h00003f80);
		tick(3);
		chk("irq global off", 32'h0, {31'h0, irq});
		cfg.globalIrqEnable <= 1'b1;
		tick(3);
		chk("irq global on", 32'h1, {31'h0, irq});
		apb(1'b1, SIC_ADDR_STATUS, 32'h00003fff);
		tick(3);
		chk("irq after clear", 32'h0, {31'h0, irq});
		apb(1'b0, SIC_ADDR_STATUS, 32'h0);
		chk("status not control", 32'h0, rd);
		$display("t_irq done");
	endtask

	task t_status;
		events.engineFifoFree <= 5'h10;
		events.cmdFifoFree <= 4'h8;
		events.peripheralBusIrq <= 1'b1;
		events.engineIdle <= 1'b1;
		tick(2);
		apb(1'b0, SIC_ADDR_STATUS, 32'h0);
		chk("status fields", 32'h00003080, {18'h0, rd[13:7], 7'h0});
		apb(1'b0, SIC_ADDR_ADVFN, 32'h0);
		chk("cmd fifo free", 32'h8, {28'h0, rd[9:6]});
		events.engineFifoFree <= 5'h00;
		events.cmdFifoFree <= 4'h0;
		events.peripheralBusIrq <= 1'b0;
		events.engineIdle <= 1'b0;
		tick(2);
		apb(1'b0, SIC_ADDR_STATUS, 32'h0);
		chk("status busy", 32'h0, {18'h0, rd[13:7], 7'h0});
		$display("t_status done");
	endtask

	task t_engrst;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, SIC_ADDR_STATUS, {16'h0, RST_SEQ[i], 14'h0});
			tick(3);
			chk("soft reset", {31'h0, RST_EXP[i]}, {31'h0, engineSoftReset});
		end
		cfg.engineResetConfigBit <= 1'b1;
		tick(3);
		chk("config reset", 32'h1, {31'h0, engineSoftReset});
		cfg.engineResetConfigBit <= 1'b0;
		apb(1'b1, SIC_ADDR_STATUS, {16'h0, SIC_RST_ENABLE, 14'h0});
		tick(3);
		chk("engine run again", 32'h0, {31'h0, engineSoftReset});
		$display("t_engrst done");
	endtask

	task t_adv;
		apb(1'b1, SIC_ADDR_ADVFN, 32'h00000013);
		tick(3);
		chk("adv outputs", 32'h7, {29'h0, enhancedModeSelect, linearAddressingEnable,
			readDmaPointerReset});
		apb(1'b0, SIC_ADDR_ADVFN, 32'h0);
		chk("adv readback", 32'h13, rd);
		// pulse back to zero as software does after a read transfer
		apb(1'b1, SIC_ADDR_ADVFN, 32'h0);
		tick(3);
		chk("adv cleared", 32'h0, {29'h0, enhancedModeSelect, linearAddressingEnable,
			readDmaPointerReset});
		cfg.enhancedModeConfig <= 1'b1;
		cfg.linearAddrConfig <= 1'b1;
		tick(3);
		chk("adv config or", 32'h6, {29'h0, enhancedModeSelect, linearAddressingEnable,
			readDmaPointerReset});
		cfg.enhancedModeConfig <= 1'b0;
		cfg.linearAddrConfig <= 1'b0;
		$display("t_adv done");
	endtask

	task t_unmapped;
		apb(1'b0, 16'h8508, 32'h0);
		chk("unmapped read err", 32'h1, {31'h0, er});
		chk("unmapped read data", 32'h0, rd);
		apb(1'b1, 16'h8500, 32'h00003f80);
		chk("unmapped write err", 32'h1, {31'h0, er});
		apb(1'b0, SIC_ADDR_STATUS, 32'h0);
		chk("mapped no err", 32'h0, {31'h0, er});
		$display("t_unmapped done");
	endtask

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		vsyncPin = 1'b0;
		events = '0;
		cfg = '0;
		fails = 0;
		n_checks = 0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		t_flags;
		t_irq;
		t_status;
		t_engrst;
		t_adv;
		t_unmapped;
		close_out;
	end
endmodule
